/* src/flrb_consts.vh */
`ifndef FLRB_CONSTS_VH
`define FLRB_CONSTS_VH

// ==========================================
// register offsets
`define FLRB_ADDR_EXT3_LIMIT      8'h32
`define FLRB_ADDR_INT_LIMIT       8'h34
`define FLRB_ADDR_DRIVE_SETTING   8'h40
`define FLRB_ADDR_CONFIG_PRIMARY  8'h42
`define FLRB_ADDR_CONFIG_SECOND   8'h43
`define FLRB_ADDR_GAIN            8'h45
`define FLRB_ADDR_SPIN_UP         8'h46
`define FLRB_ADDR_STEP            8'h47
`define FLRB_ADDR_MIN_DRIVE       8'h48
`define FLRB_ADDR_VALID_COUNT     8'h49
`define FLRB_ADDR_FAIL_BAND_LO    8'h4A
`define FLRB_ADDR_FAIL_BAND_HI    8'h4B
`define FLRB_ADDR_TARGET_LO       8'h4C
`define FLRB_ADDR_TARGET_HI       8'h4D
`define FLRB_ADDR_READING_HI      8'h4E
`define FLRB_ADDR_READING_LO      8'h4F
`define FLRB_ADDR_LOCK            8'hEF
`define FLRB_ADDR_FEATURES        8'hFC
`define FLRB_ADDR_PART_ID         8'hFD
`define FLRB_ADDR_MAKER_ID        8'hFE
`define FLRB_ADDR_REVISION        8'hFF

// ==========================================
// reset values
`define FLRB_RST_LIMIT            8'h55
`define FLRB_RST_DRIVE_SETTING    8'h00
`define FLRB_RST_CONFIG_PRIMARY   8'h2B
`define FLRB_RST_CONFIG_SECOND    8'h28
`define FLRB_RST_GAIN             8'h2A
`define FLRB_RST_SPIN_UP          8'h19
`define FLRB_RST_STEP             8'h10
`define FLRB_RST_MIN_DRIVE        8'h66
`define FLRB_RST_VALID_COUNT      8'hF5
`define FLRB_RST_FAIL_BAND        8'h00
`define FLRB_RST_TARGET_LO        8'hF8
`define FLRB_RST_TARGET_HI        8'hFF
`define FLRB_RST_READING_HI       8'hFF
`define FLRB_RST_READING_LO       8'hF8
`define FLRB_RST_LOCK             8'h00
`define FLRB_RST_FEATURES         8'h00

// ==========================================
// field positions
`define FLRB_LOCK_BIT             0
`define FLRB_CFG_ALGO_EN_BIT      7

`endif

/* src/flrb_drive_step.v */
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// one regulation update of the drive value
module flrb_drive_step
(
  input  wire [7:0]  i_current,
  input  wire [15:0] i_target_count,
  input  wire [15:0] i_reading_count,
  input  wire [7:0]  i_step,
  input  wire [7:0]  i_minimum,
  output reg  [7:0]  o_next
);

  reg [8:0] sum;
  reg [8:0] diff;
  reg [7:0] raw;

  always @*
  begin
    sum  = {1'b0, i_current} + {1'b0, i_step};
    diff = {1'b0, i_current} - {1'b0, i_step};
    raw  = i_current;
    // larger count means slower fan: raise drive, clamp at full scale
    if (i_reading_count > i_target_count)
      raw = sum[8] ? 8'hFF : sum[7:0];
    else if (i_reading_count < i_target_count)
      raw = diff[8] ? 8'h00 : diff[7:0];
    o_next = (raw < i_minimum) ? i_minimum : raw;
  end

endmodule

`default_nettype wire

/* src/flrb_register_bank.v */
`timescale 1ns/1ns
`default_nettype none
`include "flrb_consts.vh"

// Function
// - reset loads every register with its default value.
// - reads of undefined addresses return zero.
// - writes to undefined addresses change nothing.
// - while locked, lockable registers ignore writes; others stay writable.
// - lock register is itself lockable; lock cannot be cleared by writing.
// - drive setting reads back the drive last applied to the fan driver.
// - with regulation off, host write sets the fan drive directly.
// - regulation changes drive by at most the step register per update, except when raising it to the minimum drive register.
// - regulation updates never set drive below the minimum drive register.
// - fan counts as spinning when reading high byte is below valid count.
// - measured speed count readable as high and low read-only bytes.
// - target speed count held as writable low and high bytes.
// - two-byte drive fail band count held and driven out on o_fail_band.
// - external channel three high limit, lockable, default 55h.
// - internal channel high limit, lockable, default 85 degrees.
// - features register reports configuration pin selections.
// - fixed part, maker and revision codes at top addresses.
// - spin-up configuration register, lockable, default 19h.
// - gain register, lockable, default 2Ah.
module flrb_register_bank
#(
  parameter [7:0] PART_ID  = 8'hA0, // arbitrary
  parameter [7:0] MAKER_ID = 8'hA1, // arbitrary
  parameter [7:0] REV_ID   = 8'hA2  // arbitrary
)
(
  input  wire        i_clock,
  input  wire        i_reset,
  input  wire        i_enable,
  input  wire [7:0]  i_address,
  input  wire [7:0]  i_write_data,
  input  wire        i_write,
  input  wire        i_read,
  output reg  [7:0]  o_read_data,
  input  wire        i_update,
  input  wire [15:0] i_speed_count,
  input  wire [7:0]  i_feature_pins,
  output reg  [7:0]  o_fan_drive,
  output reg         o_fan_spinning,
  output reg         o_locked,
  output reg  [7:0]  o_spin_up_config,
  output reg  [7:0]  o_gain,
  output reg  [15:0] o_fail_band,
  output reg  [7:0]  o_config_secondary,
  output reg  [7:0]  o_ext3_limit,
  output reg  [7:0]  o_internal_limit
);

  // ==========================================
  // storage
  reg [7:0]  ext3_limit;
  reg [7:0]  internal_limit;
  reg [7:0]  drive;
  reg [7:0]  config_primary;
  reg [7:0]  config_secondary;
  reg [7:0]  gain;
  reg [7:0]  spin_up;
  reg [7:0]  step;
  reg [7:0]  min_drive;
  reg [7:0]  valid_count;
  reg [7:0]  fail_lo;
  reg [7:0]  fail_hi;
  reg [7:0]  target_lo;
  reg [7:0]  target_hi;
  reg [7:0]  reading_hi;
  reg [7:0]  reading_lo;
  reg [7:0]  lock_reg;
  reg [7:0]  features;
  reg [7:0]  feat_meta;
  reg [7:0]  feat_sync;
  reg        upd_meta;
  reg        upd_sync;
  reg        upd_prev;
  reg [15:0] spd_meta;
  reg [15:0] spd_sync;
  reg [7:0]  next_read;
  wire [7:0] next_drive;
  wire       locked;
  wire       algo_on;
  wire       upd_pulse;
  wire       wr_open;
  wire       wr_defined;

  assign locked    = lock_reg[`FLRB_LOCK_BIT];
  assign algo_on   = config_primary[`FLRB_CFG_ALGO_EN_BIT];
  assign upd_pulse = upd_sync & ~upd_prev;

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ==========================================
  // address classes
  // membership of the register map
  function is_defined;
    input [7:0] addr;
    begin
      is_defined = 1'b0;
      if (hit(addr, `FLRB_ADDR_EXT3_LIMIT) || hit(addr, `FLRB_ADDR_INT_LIMIT))
        is_defined = 1'b1;
      else if (hit(addr, `FLRB_ADDR_DRIVE_SETTING) || hit(addr, `FLRB_ADDR_CONFIG_PRIMARY))
        is_defined = 1'b1;
      else if (hit(addr, `FLRB_ADDR_CONFIG_SECOND))
        is_defined = 1'b1;
      else if ((addr >= `FLRB_ADDR_GAIN) && (addr <= `FLRB_ADDR_READING_LO))
        is_defined = 1'b1;
      else if (hit(addr, `FLRB_ADDR_LOCK) || (addr >= `FLRB_ADDR_FEATURES))
        is_defined = 1'b1;
    end
  endfunction

  function soft_lockable;
    input [7:0] addr;
    begin
      soft_lockable = 1'b0;
      if (hit(addr, `FLRB_ADDR_EXT3_LIMIT) || hit(addr, `FLRB_ADDR_INT_LIMIT))
        soft_lockable = 1'b1;
      else if (hit(addr, `FLRB_ADDR_CONFIG_SECOND) || hit(addr, `FLRB_ADDR_LOCK))
        soft_lockable = 1'b1;
      else if ((addr >= `FLRB_ADDR_GAIN) && (addr <= `FLRB_ADDR_FAIL_BAND_HI))
        soft_lockable = 1'b1;
    end
  endfunction

  assign wr_defined = i_write & is_defined(i_address);
  assign wr_open    = wr_defined & soft_lockable(i_address) & ~locked;

  // ==========================================
  // regulation step
  flrb_drive_step u_step
  (
    .i_current       (drive),
    .i_target_count  ({target_hi, target_lo}),
    .i_reading_count (spd_sync),
    .i_step          (step),
    .i_minimum       (min_drive),
    .o_next          (next_drive)
  );

  // ==========================================
  // external input synchronisers
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      feat_meta <= 8'h00;
      feat_sync <= 8'h00;
      upd_meta  <= 1'b0;
      upd_sync  <= 1'b0;
      upd_prev  <= 1'b0;
      spd_meta  <= 16'h0000;
      spd_sync  <= 16'h0000;
    end
    else if (i_enable)
    begin
      feat_meta <= i_feature_pins;
      feat_sync <= feat_meta;
      upd_meta  <= i_update;
      upd_sync  <= upd_meta;
      upd_prev  <= upd_sync;
      spd_meta  <= i_speed_count;
      spd_sync  <= spd_meta;
    end
  end

  // ==========================================
  // register writes
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ext3_limit       <= `FLRB_RST_LIMIT;
      internal_limit   <= `FLRB_RST_LIMIT;
      drive            <= `FLRB_RST_DRIVE_SETTING;
      config_primary   <= `FLRB_RST_CONFIG_PRIMARY;
      config_secondary <= `FLRB_RST_CONFIG_SECOND;
      gain             <= `FLRB_RST_GAIN;
      spin_up          <= `FLRB_RST_SPIN_UP;
      step             <= `FLRB_RST_STEP;
      min_drive        <= `FLRB_RST_MIN_DRIVE;
      valid_count      <= `FLRB_RST_VALID_COUNT;
      fail_lo          <= `FLRB_RST_FAIL_BAND;
      fail_hi          <= `FLRB_RST_FAIL_BAND;
      target_lo        <= `FLRB_RST_TARGET_LO;
      target_hi        <= `FLRB_RST_TARGET_HI;
      reading_hi       <= `FLRB_RST_READING_HI;
      reading_lo       <= `FLRB_RST_READING_LO;
      lock_reg         <= `FLRB_RST_LOCK;
      features         <= `FLRB_RST_FEATURES;
    end
    else if (i_enable)
    begin
      features <= feat_sync;
      if (upd_pulse)
      begin
        reading_hi <= spd_sync[15:8];
        reading_lo <= spd_sync[7:0];
      end
      if (algo_on && upd_pulse)
        drive <= next_drive;
      else if (!algo_on && i_write && hit(i_address, `FLRB_ADDR_DRIVE_SETTING))
        drive <= i_write_data;
      if (wr_defined)
      begin
        if (hit(i_address, `FLRB_ADDR_CONFIG_PRIMARY))
          config_primary <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_TARGET_LO))
          target_lo <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_TARGET_HI))
          target_hi <= i_write_data;
      end
      if (wr_open)
      begin
        if (hit(i_address, `FLRB_ADDR_EXT3_LIMIT))
          ext3_limit <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_INT_LIMIT))
          internal_limit <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_CONFIG_SECOND))
          config_secondary <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_GAIN))
          gain <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_SPIN_UP))
          spin_up <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_STEP))
          step <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_MIN_DRIVE))
          min_drive <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_VALID_COUNT))
          valid_count <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_FAIL_BAND_LO))
          fail_lo <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_FAIL_BAND_HI))
          fail_hi <= i_write_data;
        else if (hit(i_address, `FLRB_ADDR_LOCK))
          lock_reg <= i_write_data;
      end
      if (locked)
        lock_reg[`FLRB_LOCK_BIT] <= 1'b1;
    end
  end

  // ==========================================
  // read decode
  always @*
  begin
    next_read = 8'h00;
    if (hit(i_address, `FLRB_ADDR_EXT3_LIMIT))
      next_read = ext3_limit;
    else if (hit(i_address, `FLRB_ADDR_INT_LIMIT))
      next_read = internal_limit;
    else if (hit(i_address, `FLRB_ADDR_DRIVE_SETTING))
      next_read = drive;
    else if (hit(i_address, `FLRB_ADDR_CONFIG_PRIMARY))
      next_read = config_primary;
    else if (hit(i_address, `FLRB_ADDR_CONFIG_SECOND))
      next_read = config_secondary;
    else if (hit(i_address, `FLRB_ADDR_GAIN))
      next_read = gain;
    else if (hit(i_address, `FLRB_ADDR_SPIN_UP))
      next_read = spin_up;
    else if (hit(i_address, `FLRB_ADDR_STEP))
      next_read = step;
    else if (hit(i_address, `FLRB_ADDR_MIN_DRIVE))
      next_read = min_drive;
    else if (hit(i_address, `FLRB_ADDR_VALID_COUNT))
      next_read = valid_count;
    else if (hit(i_address, `FLRB_ADDR_FAIL_BAND_LO))
      next_read = fail_lo;
    else if (hit(i_address, `FLRB_ADDR_FAIL_BAND_HI))
      next_read = fail_hi;
    else if (hit(i_address, `FLRB_ADDR_TARGET_LO))
      next_read = target_lo;
    else if (hit(i_address, `FLRB_ADDR_TARGET_HI))
      next_read = target_hi;
    else if (hit(i_address, `FLRB_ADDR_READING_HI))
      next_read = reading_hi;
    else if (hit(i_address, `FLRB_ADDR_READING_LO))
      next_read = reading_lo;
    else if (hit(i_address, `FLRB_ADDR_LOCK))
      next_read = lock_reg;
    else if (hit(i_address, `FLRB_ADDR_FEATURES))
      next_read = features;
    else if (hit(i_address, `FLRB_ADDR_PART_ID))
      next_read = PART_ID;
    else if (hit(i_address, `FLRB_ADDR_MAKER_ID))
      next_read = MAKER_ID;
    else if (hit(i_address, `FLRB_ADDR_REVISION))
      next_read = REV_ID;
  end

  // ==========================================
  // registered outputs
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_read_data        <= 8'h00;
      o_fan_drive        <= `FLRB_RST_DRIVE_SETTING;
      o_fan_spinning     <= 1'b0;
      o_locked           <= 1'b0;
      o_spin_up_config   <= `FLRB_RST_SPIN_UP;
      o_gain             <= `FLRB_RST_GAIN;
      o_fail_band        <= {`FLRB_RST_FAIL_BAND, `FLRB_RST_FAIL_BAND};
      o_config_secondary <= `FLRB_RST_CONFIG_SECOND;
      o_ext3_limit       <= `FLRB_RST_LIMIT;
      o_internal_limit   <= `FLRB_RST_LIMIT;
    end
    else if (i_enable)
    begin
      o_read_data        <= i_read ? next_read : 8'h00;
      o_fan_drive        <= drive;
      // valid count compare on high byte
      o_fan_spinning     <= (reading_hi < valid_count);
      o_locked           <= locked;
      o_spin_up_config   <= spin_up;
      o_gain             <= gain;
      o_fail_band        <= {fail_hi, fail_lo};
      o_config_secondary <= config_secondary;
      o_ext3_limit       <= ext3_limit;
      o_internal_limit   <= internal_limit;
    end
  end

endmodule

`default_nettype wire

/* dv/flrb_properties.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// register bank checker
module flrb_properties
#(
  parameter [7:0] PART_ID = 8'hA0
)
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_enable,
  input wire logic [7:0]  i_address,
  input wire logic        i_write,
  input wire logic        i_read,
  input wire logic [7:0]  o_read_data,
  input wire logic [7:0]  o_fan_drive,
  input wire logic        o_locked,
  input wire logic [7:0]  o_gain,
  input wire logic [15:0] o_fail_band,
  input wire logic [7:0]  o_ext3_limit,
  input wire logic [7:0]  o_internal_limit
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);

  property p_reset_defaults;
    $past(i_reset) |-> !o_locked && o_fan_drive == 8'h00 && o_gain == 8'h2A && o_ext3_limit == 8'h55;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults missing after reset");

  property p_undef_read;
    i_enable && i_read && (i_address inside {8'h33, 8'h50}) |=> o_read_data == 8'h00;
  endproperty
  a_undef_read: assert property (p_undef_read) else $error("undefined address read not zero");

  property p_undef_write;
    i_enable && i_write && i_address == 8'h50 |=> ##1 $stable(o_gain) && $stable(o_fail_band)
      && $stable(o_ext3_limit) && $stable(o_internal_limit);
  endproperty
  a_undef_write: assert property (p_undef_write) else $error("undefined address write took effect");

  property p_locked_gain;
    o_locked && i_enable && i_write && i_address == 8'h45 |=> ##1 $stable(o_gain);
  endproperty
  a_locked_gain: assert property (p_locked_gain) else $error("gain changed while locked");

  property p_locked_ext3;
    o_locked && i_enable && i_write && i_address == 8'h32 |-> ##2 o_ext3_limit == $past(o_ext3_limit);
  endproperty
  a_locked_ext3: assert property (p_locked_ext3) else $error("limit changed while locked");

  property p_lock_sticky;
    o_locked |=> o_locked [*2];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared without reset");

  property p_drive_readback;
    i_enable && i_read && i_address == 8'h40 |=> o_read_data == o_fan_drive;
  endproperty
  a_drive_readback: assert property (p_drive_readback) else $error("drive readback differs");

  property p_part_id;
    i_enable && i_read && i_address == 8'hFD |=> o_read_data == PART_ID;
  endproperty
  a_part_id: assert property (p_part_id) else $error("part code wrong");
endmodule

bind flrb_register_bank flrb_properties #(.PART_ID(PART_ID)) u_flrb_properties
(
  .i_clock          (i_clock),
  .i_reset          (i_reset),
  .i_enable         (i_enable),
  .i_address        (i_address),
  .i_write          (i_write),
  .i_read           (i_read),
  .o_read_data      (o_read_data),
  .o_fan_drive      (o_fan_drive),
  .o_locked         (o_locked),
  .o_gain           (o_gain),
  .o_fail_band      (o_fail_band),
  .o_ext3_limit     (o_ext3_limit),
  .o_internal_limit (o_internal_limit)
);

`default_nettype wire

/* dv/fan_lock_id_register_bank_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module fan_lock_id_register_bank_tb_top;
  logic        i_clock        = 1'b0;
  logic        i_reset        = 1'b1;
  logic        i_enable       = 1'b1;
  logic [7:0]  hold;
  logic        i_write        = 1'b0;
  logic        i_read         = 1'b0;
  logic        i_update       = 1'b0;
  logic [7:0]  i_address      = 8'h00;
  logic [7:0]  i_write_data   = 8'h00;
  logic [7:0]  i_feature_pins = 8'h00;
  logic [15:0] i_speed_count  = 16'h0000;
  wire  [7:0]  o_read_data;
  wire  [7:0]  o_fan_drive;
  wire         o_fan_spinning;
  wire         o_locked;
  wire  [7:0]  o_spin_up_config;
  wire  [7:0]  o_gain;
  wire  [15:0] o_fail_band;
  wire  [7:0]  o_config_secondary;
  wire  [7:0]  o_ext3_limit;
  wire  [7:0]  o_internal_limit;
  logic [7:0]  mdl [256];
  logic [7:0]  q [$];
  logic [31:0] seed = 32'h0000_004D;
  logic        seen = 1'b0;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [7:0]  al [21] = '{8'h32, 8'h34, 8'h40, 8'h42, 8'h43, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A,
                           8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'hEF, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
  logic [7:0]  dv [21] = '{8'h55, 8'h55, 8'h00, 8'h2B, 8'h28, 8'h2A, 8'h19, 8'h10, 8'h66, 8'hF5, 8'h00,
                           8'h00, 8'hF8, 8'hFF, 8'hFF, 8'hF8, 8'h00, 8'h00, 8'hA0, 8'hA1, 8'hA2};

  always #20 i_clock = ~i_clock;

  flrb_register_bank uut
  (
    .i_clock            (i_clock),
    .i_reset            (i_reset),
    .i_enable           (i_enable),
    .i_address          (i_address),
    .i_write_data       (i_write_data),
    .i_write            (i_write),
    .i_read             (i_read),
    .o_read_data        (o_read_data),
    .i_update           (i_update),
    .i_speed_count      (i_speed_count),
    .i_feature_pins     (i_feature_pins),
    .o_fan_drive        (o_fan_drive),
    .o_fan_spinning     (o_fan_spinning),
    .o_locked           (o_locked),
    .o_spin_up_config   (o_spin_up_config),
    .o_gain             (o_gain),
    .o_fail_band        (o_fail_band),
    .o_config_secondary (o_config_secondary),
    .o_ext3_limit       (o_ext3_limit),
    .o_internal_limit   (o_internal_limit)
  );

  // ==========================================
  // helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic init_model();
    foreach (mdl[i])
      mdl[i] = 8'h00;
    foreach (al[i])
      mdl[al[i]] = dv[i];
  endtask

  // model drops refused writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_write      <= 1'b1;
    i_address    <= a;
    i_write_data <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
    if ((a inside {al}) && !(a inside {8'h4E, 8'h4F, [8'hFC:8'hFF]}) && !(a == 8'h40 && mdl[8'h42][7])
        && !(mdl[8'hEF][0] && (a inside {8'h32, 8'h34, 8'h43, [8'h45:8'h4B], 8'hEF})))
      mdl[a] = d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_read    <= 1'b1;
    i_address <= a;
    q.push_back(mdl[a]);
    @(posedge i_clock);
    i_read <= 1'b0;
  endtask

  task automatic chk_all();
    foreach (al[i])
      rd(al[i]);
    rd(8'h50);
    rd(8'h33);
  endtask

  // registered copies against the model
  task automatic chk_copies();
    @(negedge i_clock);
    chk("ext3 limit", mdl[8'h32], o_ext3_limit);
    chk("internal limit", mdl[8'h34], o_internal_limit);
    chk("config secondary", mdl[8'h43], o_config_secondary);
    chk("gain", mdl[8'h45], o_gain);
    chk("spin up", mdl[8'h46], o_spin_up_config);
    chk("fail band lo", mdl[8'h4A], o_fail_band[7:0]);
    chk("fail band hi", mdl[8'h4B], o_fail_band[15:8]);
  endtask

  // one speed measurement, regulator model
  task automatic spin(input logic [15:0] c);
    int d;
    @(posedge i_clock);
    i_speed_count <= c;
    i_update      <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_update <= 1'b0;
    repeat (6) @(posedge i_clock);
    d = mdl[8'h40];
    if (mdl[8'h42][7])
    begin
      if (c > {mdl[8'h4D], mdl[8'h4C]})
        d = d + mdl[8'h47] > 255 ? 255 : d + mdl[8'h47];
      else if (c < {mdl[8'h4D], mdl[8'h4C]})
        d = d < mdl[8'h47] ? 0 : d - mdl[8'h47];
      if (d < mdl[8'h48])
        d = mdl[8'h48];
    end
    mdl[8'h40] = d[7:0];
    mdl[8'h4E] = c[15:8];
    mdl[8'h4F] = c[7:0];
  endtask

  // ==========================================
  // read data monitor
  always @(negedge i_clock)
  begin
    if (seen)
      chk("read data", q.pop_front(), o_read_data);
    seen = i_read;
  end

  // ==========================================
  // main sequence
  initial
  begin
    init_model();
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    chk_all();
    wr(8'h50, rnd());
    foreach (al[i])
      wr(al[i], al[i] == 8'hEF ? 8'h00 : rnd());
    chk_all();
    chk_copies();
    wr(8'h42, 8'h2B);
    wr(8'h40, rnd());
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk("fan drive", mdl[8'h40], o_fan_drive);
    @(posedge i_clock);
    mdl[8'hFC] = rnd();
    i_feature_pins <= mdl[8'hFC];
    repeat (6) @(posedge i_clock);
    rd(8'hFC);
    hold = mdl[8'h4C];
    i_enable <= 1'b0;
    wr(8'h4C, ~hold);
    i_enable <= 1'b1;
    mdl[8'h4C] = hold;
    rd(8'h4C);
    wr(8'h49, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      spin({k ? 8'hF0 : 8'h10, rnd()});
      @(negedge i_clock);
      chk("spinning", mdl[8'h4E] < mdl[8'h49], o_fan_spinning);
      rd(8'h4E);
      rd(8'h4F);
    end
    wr(8'h48, 8'h20);
    wr(8'h47, 8'h10);
    wr(8'h4D, 8'h80);
    wr(8'h4C, 8'h00);
    wr(8'h40, 8'h30);
    wr(8'h42, 8'hAB);
    wr(8'h40, 8'h77);
    for (int k = 0; k < 4; k++)
    begin
      spin(k == 0 ? 16'hFFFF : 16'h0000);
      rd(8'h40);
    end
    wr(8'h42, 8'h2B);
    wr(8'hEF, 8'h01);
    @(posedge i_clock);
    @(negedge i_clock);
    chk("lock flag", 8'h01, o_locked);
    for (int k = 0; k < 17; k++)
      wr(al[k], rnd());
    wr(8'hEF, 8'h00);
    chk_all();
    chk_copies();
    @(posedge i_clock);
    i_reset        <= 1'b1;
    i_feature_pins <= 8'h00;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    init_model();
    @(negedge i_clock);
    chk("lock flag", 8'h00, o_locked);
    chk_all();
    chk_copies();
    repeat (2) @(posedge i_clock);
    end_sim();
  end
endmodule

`default_nettype wire
